// file: common/deser_cfg_map.vh
// Notes on behaviour
// - output pin drives stored output value
// - enable bit picks gpio; direction 1=input
// - override bit 7 replaces pin selects
// - bit 6 writable enable, bit 5 read-only
// - mode override blocks back channel updates
// - bits 3,2 show sampled mode pins
// - bit 1 wide mode, auto-updated
// - bit 0 narrow mode, auto-updated
// - abort transaction after timeout times 2 ms
// - disable bit 0 stops the watchdog
// - bit 7 forwards all i2c transactions
// - sda hold equals field times 50 ns
// - reject scl/sda glitches up to depth
// - sticky sequence error status bit 7
// - writing clear bit 6 clears error
`ifndef DESER_CFG_MAP_VH
`define DESER_CFG_MAP_VH

// register indices; byte address is four times the index
`define IDX_PIN_CFG 8'h1E
`define IDX_MODE_SEL 8'h1F
`define IDX_WDOG 8'h20
`define IDX_I2C_ONE 8'h21
`define IDX_I2C_TWO 8'h22
`define IDX_IRQ_STAT 8'h30
`define IDX_IRQ_EN 8'h31
`define IDX_IRQ_CLR 8'h32

`define RST_PIN_CFG 8'h03
`define RST_MODE_SEL 8'h00
`define RST_WDOG 8'h00
`define RST_I2C_ONE 8'h00
`define RST_I2C_TWO 8'h00
`define RST_IRQ_EN 3'h0

`define PIN_EN_BIT 0
`define PIN_DIR_BIT 1
`define PIN_VAL_BIT 3
`define MS_OVR_BIT 7
`define MS_OEN_BIT 6
`define MS_OSS_BIT 5
`define MS_MOVR_BIT 4
`define MS_PWIDE_BIT 3
`define MS_PNARROW_BIT 2
`define MS_WIDE_BIT 1
`define MS_NARROW_BIT 0
`define WD_DIS_BIT 0
`define WD_TMO_HI 7
`define WD_TMO_LO 1
`define I2_PASS_BIT 7
`define I2_HOLD_HI 6
`define I2_HOLD_LO 4
`define I2_DEPTH_HI 3
`define I2_DEPTH_LO 0
`define I2_SEQERR_BIT 7
`define I2_SEQCLR_BIT 6
`define IRQ_SEQERR_BIT 0
`define IRQ_WDOG_BIT 1
`define IRQ_MODE_BIT 2

// timing
`define CLK_PERIOD_NS 10
`define WD_STEP_MS 2
`define WD_STEP_CYC (`WD_STEP_MS * 1000000 / `CLK_PERIOD_NS)
`define HOLD_UNIT_NS 50
`define HOLD_UNIT_CYC (`HOLD_UNIT_NS / `CLK_PERIOD_NS)
`define DEPTH_UNIT_NS 10
`define DEPTH_UNIT_CYC (`DEPTH_UNIT_NS / `CLK_PERIOD_NS)

`endif

// file: design/pin_glitch_filter.v
`timescale 1ns/100ps
`default_nettype none
`include "deser_cfg_map.vh"
module pin_glitch_filter (
  input wire clk_in, // system clock
  input wire reset_in, // sync reset, active high
  input wire pin_in, // raw pin level
  input wire [3:0] depth_in, // longest rejected pulse, 10 ns units
  output reg level_out // filtered level
);
  reg sync1_q;
  reg sync2_q;
  reg [4:0] stable_q;

  always @(posedge clk_in) begin
    if (reset_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      stable_q <= 5'h00;
      level_out <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      // new level must outlast depth cycles before it is taken
      if (sync2_q == level_out) begin
        stable_q <= 5'h00;
      end else if (stable_q >= {1'b0, depth_in} * `DEPTH_UNIT_CYC) begin
        level_out <= sync2_q;
        stable_q <= 5'h00;
      end else begin
        stable_q <= stable_q + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/deser_cfg_regs.v
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "deser_cfg_map.vh"
module deser_cfg_regs #(
  parameter WD_STEP_CYCLES = `WD_STEP_CYC
) (
  input wire clk_in, // system clock, 100 MHz
  input wire reset_in, // sync reset, active high
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb direction, 1 = write
  input wire [7:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  output reg [31:0] prdata_out, // apb read data
  output reg pready_out, // apb ready
  output reg pslverr_out, // apb error, unmapped address
  input wire pin2_in, // third pin, input level
  output reg pin2_out, // third pin, output level
  output reg pin2_oe_out, // third pin, output enable
  input wire func2_data_in, // normal function data for third pin
  input wire func2_oe_in, // normal function enable for third pin
  input wire oen_pin_in, // output enable select pin
  input wire oss_pin_in, // output state select pin
  input wire oss_reg_src_in, // register-side output state selection
  output reg output_enable_select_out, // chosen output enable select
  output reg output_state_select_out, // chosen output state select
  input wire mode_pin_wide_in, // mode pin, wide hf mode
  input wire mode_pin_narrow_in, // mode pin, 10-bit mode
  input wire bc_mode_valid_in, // back channel mode update pulse
  input wire bc_mode_wide_in, // back channel wide hf mode
  input wire bc_mode_narrow_in, // back channel 10-bit mode
  output reg mode_wide_out, // active wide hf mode
  output reg mode_narrow_out, // active 10-bit mode
  input wire ctrl_txn_active_in, // control channel transaction busy
  output reg ctrl_abort_out, // watchdog abort pulse
  output reg passthru_all_out, // forward every i2c transaction
  input wire scl_in, // raw scl
  input wire sda_in, // raw sda
  output reg scl_filt_out, // filtered scl
  output reg sda_held_out, // filtered, hold-delayed sda
  input wire seq_err_in, // forward channel sequence error pulse
  output reg irq_out // level interrupt
);
  localparam HOLD_TAPS = 7 * `HOLD_UNIT_CYC;

  reg [7:0] pin_cfg_q;
  reg [7:0] mode_sel_q;
  reg [7:0] wdog_q;
  reg [7:0] i2c_one_q;
  reg seq_clr_q;
  reg seq_err_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_en_q;
  reg [31:0] prdata_d;
  reg addr_ok;
  reg [1:0] oen_sync_q;
  reg [1:0] oss_sync_q;
  reg [1:0] mw_sync_q;
  reg [1:0] mn_sync_q;
  reg [1:0] p2_sync_q;
  reg pwide_q;
  reg pnarrow_q;
  reg [17:0] wd_pre_q;
  reg [6:0] wd_steps_q;
  reg wd_fired_q;
  reg [HOLD_TAPS-1:0] sda_dly_q;
  reg sda_held_d;
  wire [1:0] filt_lvl;
  wire [7:0] idx;
  wire access;
  wire wr_en;
  wire mode_wr;
  wire bc_load;
  wire wd_step;
  wire wd_timeout;
  wire [2:0] irq_evt;
  wire [2:0] hold_sel;

  assign idx = {2'b00, paddr_in[7:2]};
  assign access = psel_in & penable_in;
  // a write lands only at the edge where ready is seen high
  assign wr_en = access & pready_out & pwrite_in & addr_ok;
  assign mode_wr = wr_en & (idx == `IDX_MODE_SEL);

  always @* begin
    addr_ok = (paddr_in[1:0] == 2'b00);
    prdata_d = 32'h0000_0000;
    case (idx)
      `IDX_PIN_CFG: prdata_d[7:0] = {4'h0, pin_cfg_q[3], 1'b0,
                                     pin_cfg_q[1:0]};
      `IDX_MODE_SEL: prdata_d[7:0] = {mode_sel_q[7:6], oss_reg_src_in,
                                      mode_sel_q[4], pwide_q, pnarrow_q,
                                      mode_sel_q[1:0]};
      `IDX_WDOG: prdata_d[7:0] = wdog_q;
      `IDX_I2C_ONE: prdata_d[7:0] = i2c_one_q;
      `IDX_I2C_TWO: prdata_d[7:0] = {seq_err_q, seq_clr_q, 6'h00};
      `IDX_IRQ_STAT: prdata_d[2:0] = irq_stat_q;
      `IDX_IRQ_EN: prdata_d[2:0] = irq_en_q;
      `IDX_IRQ_CLR: prdata_d = 32'h0000_0000;
      default: addr_ok = 1'b0;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always @(posedge clk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (access & ~pready_out) begin
      pready_out <= 1'b1;
      pslverr_out <= ~addr_ok;
      prdata_out <= (pwrite_in | ~addr_ok) ? 32'h0000_0000 : prdata_d;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // plain configuration registers
  always @(posedge clk_in) begin
    if (reset_in) begin
      pin_cfg_q <= `RST_PIN_CFG;
      wdog_q <= `RST_WDOG;
      i2c_one_q <= `RST_I2C_ONE;
      seq_clr_q <= 1'b0;
      irq_en_q <= `RST_IRQ_EN;
    end else if (wr_en) begin
      case (idx)
        `IDX_PIN_CFG: pin_cfg_q <= {4'h0, pwdata_in[3], 1'b0,
                                    pwdata_in[1:0]};
        `IDX_WDOG: wdog_q <= pwdata_in[7:0];
        `IDX_I2C_ONE: i2c_one_q <= pwdata_in[7:0];
        `IDX_I2C_TWO: seq_clr_q <= pwdata_in[`I2_SEQCLR_BIT];
        `IDX_IRQ_EN: irq_en_q <= pwdata_in[2:0];
        default: irq_en_q <= irq_en_q;
      endcase
    end
  end

  // pin synchronisers, first stage read by second only
  always @(posedge clk_in) begin
    if (reset_in) begin
      oen_sync_q <= 2'b00;
      oss_sync_q <= 2'b00;
      mw_sync_q <= 2'b00;
      mn_sync_q <= 2'b00;
      p2_sync_q <= 2'b00;
      pwide_q <= 1'b0;
      pnarrow_q <= 1'b0;
    end else begin
      oen_sync_q <= {oen_sync_q[0], oen_pin_in};
      oss_sync_q <= {oss_sync_q[0], oss_pin_in};
      mw_sync_q <= {mw_sync_q[0], mode_pin_wide_in};
      mn_sync_q <= {mn_sync_q[0], mode_pin_narrow_in};
      p2_sync_q <= {p2_sync_q[0], pin2_in};
      pwide_q <= mw_sync_q[1];
      pnarrow_q <= mn_sync_q[1];
    end
  end

  // back channel loads mode bits unless overridden; bus write wins
  assign bc_load = bc_mode_valid_in & ~mode_sel_q[`MS_MOVR_BIT] & ~mode_wr;

  always @(posedge clk_in) begin
    if (reset_in) begin
      mode_sel_q <= `RST_MODE_SEL;
    end else if (mode_wr) begin
      mode_sel_q <= {pwdata_in[7:6], 1'b0, pwdata_in[4], 2'b00,
                     pwdata_in[1:0]};
    end else if (bc_load) begin
      mode_sel_q[`MS_WIDE_BIT] <= bc_mode_wide_in;
      mode_sel_q[`MS_NARROW_BIT] <= bc_mode_narrow_in;
    end
  end

  // pin and select outputs
  always @(posedge clk_in) begin
    if (reset_in) begin
      pin2_out <= 1'b0;
      pin2_oe_out <= 1'b0;
      output_enable_select_out <= 1'b0;
      output_state_select_out <= 1'b0;
      mode_wide_out <= 1'b0;
      mode_narrow_out <= 1'b0;
      passthru_all_out <= 1'b0;
    end else begin
      if (pin_cfg_q[`PIN_EN_BIT]) begin
        pin2_out <= pin_cfg_q[`PIN_VAL_BIT];
        pin2_oe_out <= ~pin_cfg_q[`PIN_DIR_BIT];
      end else begin
        pin2_out <= func2_data_in;
        pin2_oe_out <= func2_oe_in;
      end
      if (mode_sel_q[`MS_OVR_BIT]) begin
        output_enable_select_out <= mode_sel_q[`MS_OEN_BIT];
        output_state_select_out <= oss_reg_src_in;
      end else begin
        output_enable_select_out <= oen_sync_q[1];
        output_state_select_out <= oss_sync_q[1];
      end
      mode_wide_out <= mode_sel_q[`MS_WIDE_BIT];
      mode_narrow_out <= mode_sel_q[`MS_NARROW_BIT];
      passthru_all_out <= i2c_one_q[`I2_PASS_BIT];
    end
  end

  // watchdog: prescaler gives a one-cycle 2 ms step while busy
  assign wd_step = (wd_pre_q == WD_STEP_CYCLES[17:0] - 18'h00001);
  // a zero timeout fires at the first step; software avoids it
  assign wd_timeout = wd_step &
    (wd_steps_q + 7'h01 >= wdog_q[`WD_TMO_HI:`WD_TMO_LO]);

  always @(posedge clk_in) begin
    if (reset_in) begin
      wd_pre_q <= 18'h00000;
      wd_steps_q <= 7'h00;
      wd_fired_q <= 1'b0;
      ctrl_abort_out <= 1'b0;
    end else begin
      ctrl_abort_out <= 1'b0;
      if (~ctrl_txn_active_in | wdog_q[`WD_DIS_BIT]) begin
        wd_pre_q <= 18'h00000;
        wd_steps_q <= 7'h00;
        wd_fired_q <= 1'b0;
      end else if (~wd_fired_q) begin
        wd_pre_q <= wd_step ? 18'h00000 : wd_pre_q + 18'h00001;
        if (wd_timeout) begin
          ctrl_abort_out <= 1'b1;
          wd_fired_q <= 1'b1;
        end else if (wd_step) begin
          wd_steps_q <= wd_steps_q + 7'h01;
        end
      end
    end
  end

  // scl and sda glitch filters
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      pin_glitch_filter u_filt (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(gi == 0 ? scl_in : sda_in),
        .depth_in(i2c_one_q[`I2_DEPTH_HI:`I2_DEPTH_LO]),
        .level_out(filt_lvl[gi])
      );
    end
  endgenerate

  // sda hold: delay line tapped at hold field times five cycles
  assign hold_sel = i2c_one_q[`I2_HOLD_HI:`I2_HOLD_LO];

  always @* begin
    if (hold_sel == 3'h0) begin
      sda_held_d = filt_lvl[1];
    end else begin
      sda_held_d = sda_dly_q[hold_sel * `HOLD_UNIT_CYC - 1];
    end
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      sda_dly_q <= {HOLD_TAPS{1'b1}};
      scl_filt_out <= 1'b1;
      sda_held_out <= 1'b1;
    end else begin
      sda_dly_q <= {sda_dly_q[HOLD_TAPS-2:0], filt_lvl[1]};
      scl_filt_out <= filt_lvl[0];
      sda_held_out <= sda_held_d;
    end
  end

  // sequence error: set beats a clear in the same cycle
  always @(posedge clk_in) begin
    if (reset_in) begin
      seq_err_q <= 1'b0;
    end else if (seq_err_in) begin
      seq_err_q <= 1'b1;
    end else if (wr_en & (idx == `IDX_I2C_TWO) &
                 pwdata_in[`I2_SEQCLR_BIT]) begin
      seq_err_q <= 1'b0;
    end
  end

  // interrupt status, write-one-to-clear through clear register
  assign irq_evt = {bc_load, ctrl_abort_out, seq_err_in};

  always @(posedge clk_in) begin
    if (reset_in) begin
      irq_stat_q <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      if (wr_en & (idx == `IDX_IRQ_CLR)) begin
        irq_stat_q <= (irq_stat_q & ~pwdata_in[2:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      irq_out <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule
`default_nettype wire

// file: bench/deser_cfg_sva.sv
`timescale 1ns/100ps
`default_nettype none
module deser_cfg_sva #(
  parameter int WD_STEP_CYCLES = 20
) (
  input wire logic clk_in, // clock
  input wire logic reset_in, // reset
  input wire logic psel_in, // apb
  input wire logic penable_in, // apb
  input wire logic pwrite_in, // apb
  input wire logic [7:0] paddr_in, // apb
  input wire logic [31:0] pwdata_in, // apb
  input wire logic pready_out, // apb
  input wire logic pin2_out, // pin
  input wire logic pin2_oe_out, // pin
  input wire logic oss_reg_src_in, // select
  input wire logic output_enable_select_out, // select
  input wire logic output_state_select_out, // select
  input wire logic bc_mode_valid_in, // mode
  input wire logic bc_mode_wide_in, // mode
  input wire logic bc_mode_narrow_in, // mode
  input wire logic mode_wide_out, // mode
  input wire logic mode_narrow_out, // mode
  input wire logic ctrl_txn_active_in, // watchdog
  input wire logic ctrl_abort_out, // watchdog
  input wire logic passthru_all_out // i2c
);
  logic wr;
  logic mwr;
  logic movr_q;
  logic [7:0] wd_q;
  int cnt_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  assign wr = psel_in & penable_in & pready_out & pwrite_in;
  assign mwr = wr & (paddr_in == 8'h7C);
  // shadows follow the edge where a write lands, not the setup cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      movr_q <= 1'b0;
      wd_q <= 8'h00;
      cnt_q <= 0;
    end else begin
      if (mwr) movr_q <= pwdata_in[4];
      if (wr && paddr_in == 8'h80) wd_q <= pwdata_in[7:0];
      cnt_q <= ctrl_txn_active_in ? cnt_q + 1 : 0;
    end
  end
  pin_out_a: assert property (
    wr && paddr_in == 8'h78 && pwdata_in[1:0] == 2'b01 |-> ##2
    pin2_oe_out && pin2_out == $past(pwdata_in[3], 2))
    else $error("gpio output wrong");
  sel_ovr_a: assert property (
    mwr && pwdata_in[7] |-> ##2
    output_enable_select_out == $past(pwdata_in[6], 2) &&
    output_state_select_out == $past(oss_reg_src_in, 2))
    else $error("override selects wrong");
  mode_load_a: assert property (
    bc_mode_valid_in && !movr_q && !mwr |-> ##2
    mode_wide_out == $past(bc_mode_wide_in, 2) &&
    mode_narrow_out == $past(bc_mode_narrow_in, 2))
    else $error("mode load wrong");
  mode_block_a: assert property (
    bc_mode_valid_in && movr_q && !mwr |-> ##2
    $stable(mode_wide_out) && $stable(mode_narrow_out))
    else $error("mode changed under override");
  mode_write_a: assert property (
    mwr |-> ##2 mode_wide_out == $past(pwdata_in[1], 2) &&
    mode_narrow_out == $past(pwdata_in[0], 2))
    else $error("mode write wrong");
  wd_time_a: assert property (
    ctrl_abort_out |-> cnt_q >= wd_q[7:1] * WD_STEP_CYCLES &&
    cnt_q <= wd_q[7:1] * WD_STEP_CYCLES + 2)
    else $error("abort at wrong time");
  wd_off_a: assert property (
    ctrl_abort_out |-> !wd_q[0])
    else $error("abort while disabled");
  pass_all_a: assert property (
    wr && paddr_in == 8'h84 |-> ##2
    passthru_all_out == $past(pwdata_in[7], 2))
    else $error("pass-through flag wrong");
  cover property (ctrl_abort_out);
  cover property (bc_mode_valid_in && movr_q);
  cover property (mwr && pwdata_in[7]);
endmodule
bind deser_cfg_regs deser_cfg_sva #(.WD_STEP_CYCLES(WD_STEP_CYCLES)) u_sva (
  .clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .pin2_out, .pin2_oe_out, .oss_reg_src_in,
  .output_enable_select_out, .output_state_select_out, .bc_mode_valid_in,
  .bc_mode_wide_in, .bc_mode_narrow_in, .mode_wide_out, .mode_narrow_out,
  .ctrl_txn_active_in, .ctrl_abort_out, .passthru_all_out);
`default_nettype wire

// file: bench/far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic clk_in, // clock
  output logic bc_valid_out, // mode pulse
  output logic bc_wide_out, // mode data
  output logic bc_narrow_out, // mode data
  output logic seq_err_out, // error pulse
  output logic txn_active_out // busy
);
  initial begin
    {bc_valid_out, bc_wide_out, bc_narrow_out} = 3'b000;
    {seq_err_out, txn_active_out} = 2'b00;
  end
  task automatic send_mode(input logic w, input logic n);
    @(posedge clk_in);
    {bc_valid_out, bc_wide_out, bc_narrow_out} <= {1'b1, w, n};
    @(posedge clk_in);
    // data is not held past the pulse
    {bc_valid_out, bc_wide_out, bc_narrow_out} <= {1'b0, ~w, ~n};
  endtask
  task automatic seq_error();
    @(posedge clk_in);
    seq_err_out <= 1'b1;
    @(posedge clk_in);
    seq_err_out <= 1'b0;
  endtask
  task automatic txn(input int len);
    @(posedge clk_in);
    txn_active_out <= 1'b1;
    repeat (len) @(posedge clk_in);
    txn_active_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top;
  localparam int STEP = 20;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel_in, penable_in, pwrite_in, pin2_in, func2_data_in, func2_oe_in;
  logic oen_pin_in, oss_pin_in, oss_reg_src_in, mode_pin_wide_in;
  logic mode_pin_narrow_in, scl_in, sda_in, err_seen, seen;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd_data;
  logic pready_out, pslverr_out, pin2_out, pin2_oe_out, scl_filt_out;
  logic output_enable_select_out, output_state_select_out, sda_held_out;
  logic mode_wide_out, mode_narrow_out, ctrl_abort_out, passthru_all_out;
  logic irq_out, bc_mode_valid_in, bc_mode_wide_in, bc_mode_narrow_in;
  logic seq_err_in, ctrl_txn_active_in;
  logic [7:0] pcfg [4] = '{8'h09, 8'h01, 8'h0B, 8'h08};
  logic [1:0] pexp [4] = '{2'b11, 2'b10, 2'b00, 2'b10};
  wire [1:0] sel = {output_enable_select_out, output_state_select_out};
  wire [1:0] mode = {mode_wide_out, mode_narrow_out};
  int error_cnt = 0;
  int check_count = 0;
  int aborts = 0;
  int gap = 0;
  deser_cfg_regs #(.WD_STEP_CYCLES(STEP)) i_dut (
    .clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pin2_in,
    .pin2_out, .pin2_oe_out, .func2_data_in, .func2_oe_in, .oen_pin_in,
    .oss_pin_in, .oss_reg_src_in, .output_enable_select_out,
    .output_state_select_out, .mode_pin_wide_in, .mode_pin_narrow_in,
    .bc_mode_valid_in, .bc_mode_wide_in, .bc_mode_narrow_in,
    .mode_wide_out, .mode_narrow_out, .ctrl_txn_active_in,
    .ctrl_abort_out, .passthru_all_out, .scl_in, .sda_in, .scl_filt_out,
    .sda_held_out, .seq_err_in, .irq_out);
  far_side_model i_far (
    .clk_in, .bc_valid_out(bc_mode_valid_in),
    .bc_wide_out(bc_mode_wide_in), .bc_narrow_out(bc_mode_narrow_in),
    .seq_err_out(seq_err_in), .txn_active_out(ctrl_txn_active_in));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (ctrl_abort_out === 1'b1) aborts <= aborts + 1;
  end
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, 24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (pready_out !== 1'b1) error_cnt++;
    {rd_data, err_seen} = {prdata_out, pslverr_out};
    {psel_in, penable_in} <= 2'b00;
    @(posedge clk_in);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [8:0] e,
      input string nm);
    apb(1'b0, a, 8'h00);
    `CHK(nm, {e[8], 24'h0, e[7:0]}, {err_seen, rd_data})
  endtask
  // scl held low for n cycles; reports any low seen after filtering
  task automatic pulse(input int n, output logic lo);
    lo = 1'b0;
    for (int i = 0; i < n + 12; i++) begin
      scl_in <= (i >= n);
      @(posedge clk_in);
      if (scl_filt_out === 1'b0) lo = 1'b1;
    end
  endtask
  // both lines fall together; cycles from filtered scl to held sda
  task automatic hold_gap(output int g);
    int t;
    t = 0;
    g = -1;
    {scl_in, sda_in} <= 2'b00;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      if (sda_held_out === 1'b0 && g < 0) g = t;
      if (scl_filt_out === 1'b0) t++;
    end
    {scl_in, sda_in} <= 2'b11;
  endtask
  initial begin
    {psel_in, penable_in, pwrite_in, pin2_in, func2_data_in} = 5'b00000;
    {oen_pin_in, oss_reg_src_in, mode_pin_narrow_in} = 3'b000;
    {func2_oe_in, oss_pin_in, mode_pin_wide_in, scl_in, sda_in} = 5'h1F;
    {paddr_in, pwdata_in} = 40'h0;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rchk(8'h78, 9'h003, "pin_cfg");
    rchk(8'h7C, 9'h008, "mode_sel");
    rchk(8'h80, 9'h000, "wdog");
    rchk(8'h84, 9'h000, "i2c_one");
    rchk(8'h88, 9'h000, "i2c_two");
    rchk(8'hFC, 9'h100, "unmapped");
    foreach (pcfg[i]) begin
      apb(1'b1, 8'h78, pcfg[i]);
      tick(2);
      `CHK("pin", pexp[i], {pin2_oe_out, pin2_out & pin2_oe_out})
    end
    oss_reg_src_in <= 1'b1;
    apb(1'b1, 8'h7C, 8'hC0);
    tick(2);
    `CHK("sel_reg", 2'b11, sel)
    rchk(8'h7C, 9'h0E8, "mode_ovr");
    oss_reg_src_in <= 1'b0;
    apb(1'b1, 8'h7C, 8'h20);
    tick(4);
    `CHK("sel_pin", 2'b01, sel)
    rchk(8'h7C, 9'h008, "oss_ro");
    i_far.send_mode(1'b1, 1'b0);
    tick(2);
    `CHK("mode_bc", 2'b10, mode)
    apb(1'b1, 8'h7C, 8'h12);
    i_far.send_mode(1'b0, 1'b1);
    tick(2);
    `CHK("mode_held", 2'b10, mode)
    apb(1'b1, 8'h7C, 8'h00);
    i_far.send_mode(1'b0, 1'b1);
    tick(2);
    rchk(8'h7C, 9'h009, "mode_rd");
    i_far.seq_error();
    tick(1);
    rchk(8'h88, 9'h080, "seq_err");
    `CHK("irq_mask", 1'b0, irq_out)
    apb(1'b1, 8'hC4, 8'h01);
    tick(1);
    `CHK("irq_on", 1'b1, irq_out)
    rchk(8'hC0, 9'h005, "irq_stat");
    apb(1'b1, 8'h88, 8'h40);
    rchk(8'h88, 9'h040, "seq_clr");
    apb(1'b1, 8'hC8, 8'h07);
    tick(1);
    `CHK("irq_off", 1'b0, irq_out)
    rchk(8'hC0, 9'h000, "irq_clr");
    apb(1'b1, 8'h80, 8'h04); // nonzero timeout
    i_far.txn(2 * STEP - 5);
    `CHK("no_abort", 0, aborts)
    i_far.txn(2 * STEP + 10);
    apb(1'b1, 8'h80, 8'h05);
    i_far.txn(2 * STEP + 10);
    tick(2);
    `CHK("aborts", 1, aborts)
    rchk(8'hC0, 9'h002, "wd_stat");
    apb(1'b1, 8'h84, 8'h83);
    tick(2);
    `CHK("pass_all", 1'b1, passthru_all_out)
    pulse(3, seen);
    `CHK("glitch", 1'b0, seen)
    pulse(4, seen);
    `CHK("edge", 1'b1, seen)
    apb(1'b1, 8'h84, 8'hA0); // hold of 2 units, no filtering
    hold_gap(gap);
    `CHK("sda_hold", 10, gap)
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
